// ==== bench/fcs_chk.sv ====
// Port checker for the configuration sequencer
`timescale 1ns/1ps
`default_nettype none
module fcs_chk (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Watched inputs
    input wire fcs_pkg::fcs_cfg_t i_cfg,
    input wire logic i_config_reset_n,
    input wire logic i_tck,
    // Watched outputs
    input wire logic o_config_clock,
    input wire logic o_config_clock_oe,
    input wire logic o_tdo,
    input wire logic o_tdo_oe,
    input wire fcs_pkg::fcs_stat_t o_stat,
    input wire logic o_user_reset
);
    int unsigned done_r;
    int unsigned lo_r;
    int unsigned hi_r;
    logic fast;
    logic ld;
    logic dn;
    assign fast = i_cfg.quarter_rate_divider | (i_cfg.bus_width == 4'h2) |
        (i_cfg.bus_width == 4'h4);
    assign ld = o_stat.loading;
    assign dn = o_stat.config_done_flag;
    // Low run is held after release, since done may drop a little later
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            done_r <= 0;
            lo_r <= 0;
            hi_r <= 0;
        end else begin
            done_r <= dn ? done_r + 1 : 0;
            hi_r <= i_config_reset_n ? hi_r + 1 : 0;
            if (!i_config_reset_n)
                lo_r <= (hi_r != 0) ? 1 : lo_r + 1;
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    a_done_off_load: assert property (
        ld |-> !dn)
        else $error("done high while loading");
    a_user_after_wait: assert property (
        $rose(o_stat.user_mode) |-> done_r >= fcs_pkg::USER_MIN_CYC)
        else $error("user mode too early");
    a_user_needs_done: assert property (
        o_stat.user_mode |-> dn)
        else $error("user mode without done");
    a_sys_reset_tie: assert property (
        o_user_reset != o_stat.user_mode)
        else $error("user reset not inverse of user mode");
    a_pulse_long: assert property (
        $fell(dn) |-> lo_r >= fcs_pkg::RESET_PULSE_CYC)
        else $error("short pulse restarted");
    a_wait_first: assert property (
        $rose(dn) |-> hi_r > fcs_pkg::DATA_WAIT_CYC)
        else $error("done inside data wait");
    a_clk_fast_rate: assert property (
        $rose(o_config_clock) && fast |-> ##1 (!$rose(o_config_clock))[*3]
        ##1 ($rose(o_config_clock) || !ld))
        else $error("quarter rate period not 4");
    a_clk_slow_rate: assert property (
        $rose(o_config_clock) && !fast |-> ##1 (!$rose(o_config_clock))[*7]
        ##1 ($rose(o_config_clock) || !ld))
        else $error("slow rate period not 8");
    a_clk_oe_mode: assert property (
        o_config_clock_oe |-> i_cfg.mode == fcs_pkg::FCS_MODE_ACTIVE)
        else $error("clock oe off mode");
    a_tdo_on_fall: assert property (
        $changed(o_tdo) |-> !$past(i_tck, 2))
        else $error("tdo changed after tck rise");
    a_tdo_oe_mode: assert property (
        o_tdo_oe |-> i_cfg.mode == fcs_pkg::FCS_MODE_JTAG)
        else $error("tdo oe off mode");
    c_user: cover property ($rose(o_stat.user_mode));
    c_fast: cover property ($rose(o_config_clock) && fast);
    c_slow: cover property ($rose(o_config_clock) && !fast);
    c_tdo: cover property ($rose(o_tdo_oe));
endmodule // fcs_chk
bind fcs_sequencer fcs_chk u_chk (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_cfg(i_cfg),
    .i_config_reset_n(i_config_reset_n), .i_tck(i_tck),
    .o_config_clock(o_config_clock), .o_config_clock_oe(o_config_clock_oe),
    .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_stat(o_stat),
    .o_user_reset(o_user_reset));
`default_nettype wire

// ==== bench/fcs_host_model.sv ====
// Far side: configuration host, flash data and test access host
`timescale 1ns/1ps
`default_nettype none
module fcs_host_model (
    // Clock
    input wire logic i_core_clk,
    // Configuration pins
    output logic o_config_reset_n,
    output logic o_config_clock,
    output logic [7:0] o_config_data,
    // Test access pins
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi
);
    initial begin
        o_config_reset_n = 1'b1;
        o_config_clock = 1'b0;
        o_config_data = 8'h00;
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
    end
    // Content is not interpreted, so never let a stale byte look stable
    always @(posedge i_core_clk)
        o_config_data <= o_config_data + 8'h3b;
    task automatic step(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task automatic pulse(input int n);
        o_config_reset_n = 1'b0;
        step(n);
        o_config_reset_n = 1'b1;
    endtask
    task automatic pclk(input int n, input int half);
        repeat (n) begin
            o_config_clock = 1'b1;
            step(half);
            o_config_clock = 1'b0;
            step(half);
        end
    endtask
    task automatic tbit(input logic ms, input logic di);
        o_tms = ms;
        o_tdi = di;
        step(4);
        o_tck = 1'b1;
        step(4);
        o_tck = 1'b0;
    endtask
    task automatic walk(input logic [7:0] ms, input int k);
        for (int i = 0; i < k; i++)
            tbit(ms[i], 1'b0);
    endtask
    task automatic shift(input int n);
        repeat (n - 1) tbit(1'b0, 1'b1);
        tbit(1'b1, 1'b0);
    endtask
    task automatic load_ir(input logic [3:0] ir);
        walk(8'h03, 4);
        for (int i = 0; i < 4; i++)
            tbit(i == 3, ir[i]);
        walk(8'h01, 2);
    endtask
endmodule // fcs_host_model
`default_nettype wire

// ==== bench/fcs_sequencer_bench.sv ====
// Self-checking bench for the configuration sequencer
`timescale 1ns/1ps
`default_nettype none
module fcs_sequencer_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    fcs_pkg::fcs_cfg_t cfg = '0;
    wire logic rn, cc, tck, tms, tdi, occ, oe, tdo, toe, ur;
    wire logic [7:0] dat;
    wire fcs_pkg::fcs_stat_t st;
    int errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int rises = 0;
    logic occ_q = 1'b0;
    logic toe_seen = 1'b0;
    always #5 clk = ~clk;
    fcs_host_model host (.i_core_clk(clk), .o_config_reset_n(rn),
        .o_config_clock(cc), .o_config_data(dat), .o_tck(tck), .o_tms(tms),
        .o_tdi(tdi));
    fcs_sequencer uut (.i_core_clk(clk), .i_rst(rst), .i_cfg(cfg),
        .i_config_reset_n(rn), .i_config_clock(cc), .i_config_data(dat),
        .o_config_clock(occ), .o_config_clock_oe(oe), .i_tck(tck),
        .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(toe), .o_stat(st),
        .o_user_reset(ur));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        occ_q <= occ;
        if (occ === 1'b1 && occ_q === 1'b0)
            rises <= rises + 1;
        if (toe === 1'b1)
            toe_seen <= 1'b1;
        if (cyc == 90000) begin
            errors++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wait_bit(input int b, output int n);
        n = 0;
        while (st[b] !== 1'b1 && n < 12000) begin
            host.step(1);
            n++;
        end
    endtask
    task automatic user_chk();
        int n;
        wait_bit(1, n);
        chk(n > 1180 && n < 1210, 1);
        chk(ur, 0);
    endtask
    task automatic start(input fcs_pkg::fcs_mode_t m, input logic q,
            input logic [3:0] w);
        rst = 1'b1;
        cfg = '{mode: m, quarter_rate_divider: q, bus_width: w};
        host.step(5);
        rst = 1'b0;
        rises = 0;
        host.step(2);
        host.pulse(40);
    endtask
    // Edges inside the wait are refused, then the exact count ends loading
    task automatic t_passive(input logic [3:0] w, input int half);
        int n;
        n = fcs_pkg::CHAIN_BITS / w;
        start(fcs_pkg::FCS_MODE_PASSIVE, 1'b0, w);
        host.step(10);
        host.pclk(3, half);
        host.step(fcs_pkg::DATA_WAIT_CYC);
        host.pclk(n - 1, half);
        host.step(8);
        chk(st.config_done_flag, 0);
        host.pclk(1, half);
        host.step(8);
        chk(st.config_done_flag, 1);
        user_chk();
    endtask
    // The qualified pin hold keeps the reset state a few cycles after release
    task automatic t_active(input logic q, input logic [3:0] w, input int k);
        int n;
        start(fcs_pkg::FCS_MODE_ACTIVE, q, w);
        host.step(6);
        chk(oe, 1);
        wait_bit(2, n);
        user_chk();
        chk(rises, k);
    endtask
    // Done alone must not start the interval over the test port
    task automatic t_jtag();
        int n;
        start(fcs_pkg::FCS_MODE_JTAG, 1'b0, 4'h1);
        host.step(130);
        host.walk(8'h1f, 5);
        // Reach Shift-DR without a rise in it: every later rise takes a bit
        host.walk(8'h02, 3);
        host.shift(fcs_pkg::CHAIN_BITS);
        host.walk(8'h00, 1);
        chk(st.config_done_flag, 1);
        host.step(1500);
        chk(st.user_mode, 0);
        chk(toe_seen, 0);
        host.load_ir(fcs_pkg::IR_ENTER_USER);
        wait_bit(1, n);
        chk(n > 1180 && n < 1210, 1);
        chk(toe_seen, 1);
        chk(toe, 0);
        chk(tdo, fcs_pkg::IR_ENTER_USER[0]);
    endtask
    initial begin
        t_passive(4'h1, 2);
        host.pulse(20);
        host.step(60);
        chk(st, 3'h6);
        host.pulse(40);
        host.step(4);
        chk(st.config_done_flag, 0);
        t_passive(4'h8, 1);
        t_active(1'b0, 4'h1, 1344);
        t_active(1'b1, 4'h1, 1344);
        t_active(1'b0, 4'h2, 672);
        t_active(1'b0, 4'h4, 336);
        t_jtag();
        close_out();
    end
endmodule // fcs_sequencer_bench
`default_nettype wire

// ==== common/fcs_pkg.sv ====
// Shared constants and carrier types for the configuration sequencer
package fcs_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned CLK_PERIOD_NS = 10;
    // Reset low pulse needed to restart loading, ns (least: round up)
    localparam int unsigned RESET_PULSE_NS = 320;
    localparam int unsigned RESET_PULSE_CYC =
        (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Post-done interval before user mode, us (least: round up)
    localparam int unsigned USER_MIN_US = 12;
    localparam int unsigned USER_MIN_CYC = USER_MIN_US * CLK_MHZ;
    // Wait from reset release to first data in every mode, ns
    localparam int unsigned DATA_WAIT_NS = 1200;
    localparam int unsigned DATA_WAIT_CYC =
        (DATA_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Active clock: 100 MHz / 4 = 25 MHz (14..26), / 8 = 12.5 MHz (7..13)
    localparam int unsigned QUARTER_HALF_CYC = 2;
    localparam int unsigned SLOW_HALF_CYC = 4;
    // Bits per image before done; chain master length figure
    localparam int unsigned CHAIN_BITS = 1344;
    localparam int unsigned CNT_W = 16;
    localparam logic [3:0] IR_ENTER_USER = 4'h7;
    localparam int unsigned IR_W = 4;

    typedef enum logic [1:0] {
        FCS_MODE_ACTIVE,
        FCS_MODE_PASSIVE,
        FCS_MODE_JTAG
    } fcs_mode_t;

    // Static strap settings of the loader
    typedef struct packed {
        fcs_mode_t mode;
        logic quarter_rate_divider;
        logic [3:0] bus_width;
    } fcs_cfg_t;

    // Status seen by the outside world
    typedef struct packed {
        logic config_done_flag;
        logic user_mode;
        logic loading;
    } fcs_stat_t;
endpackage : fcs_pkg

// ==== logic/fcs_clk_div.sv ====
// Active-mode configuration clock divider and rise enable
`timescale 1ns/1ps
`default_nettype none
module fcs_clk_div (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Control
    input wire logic i_run,
    input wire logic i_quarter_rate_divider,
    // Divided clock and its rise enable
    output logic o_config_clock,
    output logic o_rise
);
    logic [2:0] cnt_r;
    logic clk_r;
    logic rise_r;
    wire [2:0] half_w = i_quarter_rate_divider ?
        3'(fcs_pkg::QUARTER_HALF_CYC - 1) : 3'(fcs_pkg::SLOW_HALF_CYC - 1);
    wire wrap_w = (cnt_r >= half_w);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r <= 3'h0;
            clk_r <= 1'b0;
            rise_r <= 1'b0;
        end else if (!i_run) begin
            cnt_r <= 3'h0;
            clk_r <= 1'b0;
            rise_r <= 1'b0;
        end else begin
            cnt_r <= wrap_w ? 3'h0 : cnt_r + 3'h1;
            clk_r <= wrap_w ? ~clk_r : clk_r;
            rise_r <= wrap_w & ~clk_r;
        end
    end
    assign o_config_clock = clk_r;
    assign o_rise = rise_r;
endmodule // fcs_clk_div
`default_nettype wire

// ==== logic/fcs_sequencer.sv ====
// Configuration sequencer: reset trigger, loading, done and user entry
`timescale 1ns/1ps
`default_nettype none
module fcs_sequencer (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Straps
    input wire fcs_pkg::fcs_cfg_t i_cfg,
    // Configuration pins
    input wire logic i_config_reset_n,
    input wire logic i_config_clock,
    input wire logic [7:0] i_config_data,
    output logic o_config_clock,
    output logic o_config_clock_oe,
    // Test access pins
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_tdo_oe,
    // Status
    output fcs_pkg::fcs_stat_t o_stat,
    output logic o_user_reset
);
    typedef enum logic [2:0] {
        ST_RESET, ST_WAIT, ST_LOAD, ST_DONE, ST_USER
    } fcs_state_t;

    // Two-flop synchronisers for all pins
    logic [11:0] s1_r;
    logic [11:0] s2_r;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_r <= 12'h000;
            s2_r <= 12'h000;
        end else begin
            s1_r <= {i_config_reset_n, i_config_clock, i_tck, i_tms,
                     i_config_data};
            s2_r <= s1_r;
        end
    end
    wire rst_n_w = s2_r[11];
    wire pclk_w = s2_r[10];
    wire tck_w = s2_r[9];
    wire tms_w = s2_r[8];
    wire [7:0] data_w = s2_r[7:0];
    logic tdi_s1_r;
    logic tdi_r;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            tdi_s1_r <= 1'b0;
            tdi_r <= 1'b0;
        end else begin
            tdi_s1_r <= i_tdi;
            tdi_r <= tdi_s1_r;
        end
    end

    // Edge history on synchronised pins
    logic pclk_d_r;
    logic tck_d_r;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pclk_d_r <= 1'b0;
            tck_d_r <= 1'b0;
        end else begin
            pclk_d_r <= pclk_w;
            tck_d_r <= tck_w;
        end
    end
    wire pclk_rise_w = pclk_w & ~pclk_d_r;
    wire tck_rise_w = tck_w & ~tck_d_r;
    wire tck_fall_w = ~tck_w & tck_d_r;

    // Reset pulse width counter; strap sampled at reset release
    logic [fcs_pkg::CNT_W-1:0] low_cnt_r;
    wire low_ok_w = (low_cnt_r >= fcs_pkg::CNT_W'(fcs_pkg::RESET_PULSE_CYC));
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            low_cnt_r <= '0;
        end else if (rst_n_w) begin
            low_cnt_r <= '0;
        end else if (!low_ok_w) begin
            low_cnt_r <= low_cnt_r + 1'b1;
        end
    end

    fcs_state_t state_r;
    fcs_state_t state_nxt;
    logic [fcs_pkg::CNT_W-1:0] cnt_r;
    logic [fcs_pkg::CNT_W-1:0] cnt_nxt;
    fcs_pkg::fcs_cfg_t cfg_r;

    // Effective divider: bus width 2 or 4 forces quarter rate
    logic div_fast_w;
    assign div_fast_w = cfg_r.quarter_rate_divider |
        (cfg_r.bus_width == 4'h2) | (cfg_r.bus_width == 4'h4);

    logic act_rise_w;
    logic act_clk_w;
    wire act_run_w = (state_r == ST_LOAD) &&
        (cfg_r.mode == fcs_pkg::FCS_MODE_ACTIVE);
    fcs_clk_div u_div (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_run(act_run_w),
        .i_quarter_rate_divider(div_fast_w),
        .o_config_clock(act_clk_w),
        .o_rise(act_rise_w)
    );

    // JTAG TAP: compact state tracking, IR shift and update
    typedef enum logic [3:0] {
        T_RESET, T_IDLE, T_DRSEL, T_DRSH, T_DRUPD,
        T_IRSEL, T_IRCAP, T_IRSH, T_IREX1, T_IRUPD
    } fcs_tap_t;
    fcs_tap_t tap_r;
    fcs_tap_t tap_nxt;
    logic [fcs_pkg::IR_W-1:0] ir_sh_r;
    logic enter_user_instruction_r;
    always_comb begin
        tap_nxt = tap_r;
        case (tap_r)
            T_RESET: tap_nxt = tms_w ? T_RESET : T_IDLE;
            T_IDLE: tap_nxt = tms_w ? T_DRSEL : T_IDLE;
            T_DRSEL: tap_nxt = tms_w ? T_IRSEL : T_DRSH;
            T_DRSH: tap_nxt = tms_w ? T_DRUPD : T_DRSH;
            T_DRUPD: tap_nxt = tms_w ? T_DRSEL : T_IDLE;
            T_IRSEL: tap_nxt = tms_w ? T_RESET : T_IRCAP;
            T_IRCAP: tap_nxt = tms_w ? T_IREX1 : T_IRSH;
            T_IRSH: tap_nxt = tms_w ? T_IREX1 : T_IRSH;
            T_IREX1: tap_nxt = tms_w ? T_IRUPD : T_IRSH;
            T_IRUPD: tap_nxt = tms_w ? T_DRSEL : T_IDLE;
            default: tap_nxt = T_RESET;
        endcase
    end
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            tap_r <= T_RESET;
            ir_sh_r <= '0;
            enter_user_instruction_r <= 1'b0;
        end else if (tck_rise_w) begin
            tap_r <= tap_nxt;
            if (tap_r == T_IRSH) begin
                ir_sh_r <= {tdi_r, ir_sh_r[fcs_pkg::IR_W-1:1]};
            end
            if (tap_r == T_IRUPD) begin
                enter_user_instruction_r <=
                    (ir_sh_r == fcs_pkg::IR_ENTER_USER);
            end
        end
    end

    logic tdo_r;
    logic tdo_oe_r;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            tdo_r <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else if (tck_fall_w) begin
            tdo_r <= ir_sh_r[0];
            tdo_oe_r <= (tap_r == T_IRSH);
        end
    end

    // Data acceptance strobe per mode; bits counted by bus width
    wire take_w = (cfg_r.mode == fcs_pkg::FCS_MODE_ACTIVE) ? act_rise_w :
        (cfg_r.mode == fcs_pkg::FCS_MODE_PASSIVE) ? pclk_rise_w :
        (tck_rise_w && tap_r == T_DRSH);
    wire [3:0] width_w = (cfg_r.bus_width == 4'h0) ? 4'h1 : cfg_r.bus_width;
    wire load_end_w = (cnt_r + fcs_pkg::CNT_W'(width_w)) >=
        fcs_pkg::CNT_W'(fcs_pkg::CHAIN_BITS);
    wire jtag_w = (cfg_r.mode == fcs_pkg::FCS_MODE_JTAG);
    wire user_start_w = !jtag_w || enter_user_instruction_r;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_RESET: begin
                cnt_nxt = '0;
                if (rst_n_w) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r >= fcs_pkg::CNT_W'(fcs_pkg::DATA_WAIT_CYC - 1)) begin
                    state_nxt = ST_LOAD;
                    cnt_nxt = '0;
                end
            end
            ST_LOAD: begin
                if (take_w) begin
                    cnt_nxt = cnt_r + fcs_pkg::CNT_W'(width_w);
                    if (load_end_w) begin
                        state_nxt = ST_DONE;
                        cnt_nxt = '0;
                    end
                end
            end
            ST_DONE: begin
                if (user_start_w) begin
                    cnt_nxt = cnt_r + 1'b1;
                end
                if (cnt_r >= fcs_pkg::CNT_W'(fcs_pkg::USER_MIN_CYC - 1)) begin
                    state_nxt = ST_USER;
                end
            end
            ST_USER: state_nxt = ST_USER;
            default: state_nxt = ST_RESET;
        endcase
        if (low_ok_w) begin
            state_nxt = ST_RESET;
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= ST_RESET;
            cnt_r <= '0;
            cfg_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            if (state_r == ST_RESET) begin
                cfg_r <= i_cfg;
            end
        end
    end

    // Outputs, all registered except o_user_reset, which is the inverse of user_r
    logic done_r;
    logic user_r;
    logic cclk_r;
    logic cclk_oe_r;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            done_r <= 1'b0;
            user_r <= 1'b0;
            cclk_r <= 1'b0;
            cclk_oe_r <= 1'b0;
        end else begin
            done_r <= (state_nxt == ST_DONE) || (state_nxt == ST_USER);
            user_r <= (state_nxt == ST_USER);
            cclk_r <= act_clk_w;
            cclk_oe_r <= (cfg_r.mode == fcs_pkg::FCS_MODE_ACTIVE) &&
                (state_r != ST_RESET);
        end
    end
    logic loading_r;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            loading_r <= 1'b0;
        end else begin
            loading_r <= (state_nxt == ST_LOAD);
        end
    end
    // Data bits themselves are consumed by the core loader, not here
    wire unused_w = ^data_w;

    assign o_config_clock = cclk_r;
    assign o_config_clock_oe = cclk_oe_r;
    assign o_tdo = tdo_r;
    assign o_tdo_oe = tdo_oe_r;
    assign o_stat = '{config_done_flag: done_r, user_mode: user_r,
                      loading: loading_r};
    assign o_user_reset = ~user_r;
endmodule // fcs_sequencer
`default_nettype wire
